// ===== bench/pdf_ctrl_model.sv
// board controller model: owns the sleep pin and the input pins
// assumes the bench asks for sleep on sleep_cmd_i, pin data on data_i
`timescale 1ns/1ps
`default_nettype none
module pdf_ctrl_model (
   input  wire logic                          clk_i,
   input  wire logic                          sleep_cmd_i,
   input  wire logic [pdf_pkg::PDF_WIDTH-1:0] data_i,
   output var  logic                          sleep_o,
   output var  logic [pdf_pkg::PDF_WIDTH-1:0] pin_o
);
   import pdf_pkg::*;
   int unsigned          settle = 0;
   logic                 cmd_q  = 1'b0;
   logic [PDF_WIDTH-1:0] data_q = 16'h0000;
   // bench requests taken mid-cycle where they are steady; costs a cycle
   // but avoids racing the bench at the falling edge
   always @(posedge clk_i) begin
      cmd_q  <= sleep_cmd_i;
      data_q <= data_i;
   end
   // pins steady before sleep, free only after the stop limit
   always @(negedge clk_i) begin
      if (!cmd_q) begin
         sleep_o <= 1'b0;
         settle <= 0;
         pin_o <= data_q;
      end else if (settle < INPUT_VALID_CYC) begin
         settle <= settle + 1;
         pin_o <= data_q;
      end else if (settle < INPUT_VALID_CYC + STOP_MAX_CYC) begin
         sleep_o <= 1'b1;
         settle <= settle + 1;
      end else begin
         // pins change every cycle, so a stale sample cannot look right
         pin_o <= ~pin_o;
      end
   end
endmodule
`default_nettype wire

// ===== bench/pdf_freeze_tb.sv
// self-checking bench for the power-down freeze block
// assumes the controller model drives the sleep pin and the input pins
`timescale 1ns/1ps
`default_nettype none
module pdf_freeze_tb;
   import pdf_pkg::*;
   logic                 clk = 1'b0;
   logic                 rst = 1'b1;
   logic                 opt = 1'b1;
   logic                 cmd = 1'b0;
   logic [PDF_WIDTH-1:0] data = 16'h0000;
   logic [PDF_WIDTH-1:0] cout = 16'h0000;
   logic [PDF_WIDTH-1:0] coe = 16'h0000;
   logic                 slp;
   logic                 sic;
   logic                 hold;
   logic                 pda;
   logic                 rdy;
   logic [PDF_WIDTH-1:0] pin;
   logic [PDF_WIDTH-1:0] tcore;
   logic [PDF_WIDTH-1:0] pout;
   logic [PDF_WIDTH-1:0] poe;
   int                   err_total = 0;
   int                   n_checks = 0;
   // 4 ns clock
   always #2 clk = ~clk;
   pdf_ctrl_model i_pdf_ctrl_model (.clk_i(clk), .sleep_cmd_i(cmd),
      .data_i(data), .sleep_o(slp), .pin_o(pin));
   pdf_freeze i_pdf_freeze (.clk_i(clk), .rst_i(rst), .pd_option_i(opt),
      .sleep_request_pin_i(slp), .pin_in_i(pin), .core_out_i(cout),
      .core_oe_i(coe), .to_core_o(tcore), .pin_out_o(pout),
      .pin_oe_o(poe), .sleep_in_core_o(sic), .core_hold_o(hold),
      .pd_active_o(pda), .ready_o(rdy));
   task automatic chk(input string what, input logic [15:0] exp,
                      input logic [15:0] got);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic summarize();
      if (err_total == 0 && n_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   // waits for a flag (0 power-down, 1 ready); a spent bound ends the run
   task automatic wait_for(input int sel, input logic v);
      int i;
      i = 0;
      while ((sel == 0 ? pda : rdy) !== v && i < 300) begin
         cyc(1);
         i++;
      end
      if ((sel == 0 ? pda : rdy) !== v) begin
         err_total++;
         summarize();
      end
   endtask
   task automatic do_reset(input logic o);
      opt = o;
      rst = 1'b1;
      cmd = 1'b0;
      cyc(16);
      chk("ready", 16'h0001, {15'h0000, rdy});
      chk("pin_oe", 16'h0000, poe);
      rst = 1'b0;
      cyc(2);
   endtask
   task automatic t_run();
      data = 16'hA5C3;
      cout = 16'h1234;
      coe = 16'h00FF;
      cyc(2);
      chk("to_core", 16'hA5C3, tcore);
      chk("pin_out", 16'h1234, pout);
      chk("pin_oe", 16'h00FF, poe);
      chk("sleep_in_core", 16'h0000, {15'h0000, sic});
   endtask
   task automatic t_sleep();
      int n;
      data = 16'h3C3C;
      cout = 16'h5A5A;
      coe = 16'h0F0F;
      cmd = 1'b1;
      wait_for(0, 1'b1);
      chk("ready", 16'h0000, {15'h0000, rdy});
      cout = 16'hA5A5;
      coe = 16'hF0F0;
      cyc(12);
      chk("to_core", 16'h3C3C, tcore);
      chk("pin_out", 16'h5A5A, pout);
      chk("pin_oe", 16'h0F0F, poe);
      chk("core_hold", 16'h0001, {15'h0000, hold});
      chk("sleep_in_core", 16'h0000, {15'h0000, sic});
      data = 16'hC0DE;
      cmd = 1'b0;
      wait_for(0, 1'b0);
      n = 0;
      while (rdy !== 1'b1 && n < 300) begin
         chk("to_core", 16'h3C3C, tcore);
         chk("core_hold", 16'h0001, {15'h0000, hold});
         cyc(1);
         n++;
      end
      if (rdy !== 1'b1) begin
         err_total++;
         summarize();
      end
      chk("wake cycles", {8'h00, WAKE_CYC}, n[15:0]);
      chk("wake limit", 16'h0001, {15'h0000, n <= WAKE_MAX_CYC});
      chk("pin_out", 16'h5A5A, pout);
      cyc(1);
      chk("to_core", 16'hC0DE, tcore);
      chk("pin_oe", 16'hF0F0, poe);
   endtask
   // sleep returns during recovery: straight back to sleep, no release
   task automatic t_rewake();
      cout = 16'h0F0F;
      cyc(2);
      cmd = 1'b1;
      wait_for(0, 1'b1);
      cout = 16'hF00F;
      cmd = 1'b0;
      wait_for(0, 1'b0);
      cmd = 1'b1;
      wait_for(0, 1'b1);
      chk("ready", 16'h0000, {15'h0000, rdy});
      chk("core_hold", 16'h0001, {15'h0000, hold});
      chk("pin_out", 16'h0F0F, pout);
      cmd = 1'b0;
      wait_for(1, 1'b1);
      cyc(2);
      chk("pin_out", 16'hF00F, pout);
   endtask
   task automatic t_no_option();
      cmd = 1'b1;
      cyc(8);
      chk("pd_active", 16'h0000, {15'h0000, pda});
      chk("ready", 16'h0001, {15'h0000, rdy});
      chk("sleep_in_core", 16'h0001, {15'h0000, sic});
      cmd = 1'b0;
      cyc(2);
   endtask
   initial begin
      do_reset(1'b1);
      t_run();
      t_sleep();
      t_rewake();
      do_reset(1'b0);
      t_no_option();
      summarize();
   end
endmodule
`default_nettype wire

// ===== logic/pdf_freeze.sv
// power-down freeze sequencer between the pins and the user logic core
// assumes the core stalls its registers while core_hold_o is high
// What this block does
// - with the option on, a high sleep request pin means power-down.
// - in power-down all state and outputs are captured and held unchanged.
// - outputs tristated when power-down begins stay tristated throughout.
// - in power-down every input except the sleep pin is blocked.
// - pin hold latches stay active so pins keep a defined level.
// - with the option on, the sleep pin reaches the core logic only in the first cycle after reset release, before the option is caught.
// - the sleep pin's macrocell outputs remain usable by other logic.
// - sampling of inputs stops within 25 ns after sleep rises.
// - after sleep falls, valid operation returns within 1 us.
`timescale 1ns/1ps
`default_nettype none
module pdf_freeze (
   input  wire logic                         clk_i,
   input  wire logic                         rst_i,
   input  wire logic                         pd_option_i,
   input  wire logic                         sleep_request_pin_i,
   input  wire logic [pdf_pkg::PDF_WIDTH-1:0] pin_in_i,
   input  wire logic [pdf_pkg::PDF_WIDTH-1:0] core_out_i,
   input  wire logic [pdf_pkg::PDF_WIDTH-1:0] core_oe_i,
   output var  logic [pdf_pkg::PDF_WIDTH-1:0] to_core_o,
   output var  logic [pdf_pkg::PDF_WIDTH-1:0] pin_out_o,
   output var  logic [pdf_pkg::PDF_WIDTH-1:0] pin_oe_o,
   output var  logic                         sleep_in_core_o,
   output var  logic                         core_hold_o,
   output var  logic                         pd_active_o,
   output var  logic                         ready_o
);
   import pdf_pkg::*;

   localparam int A_STOP_MAX = 2;

   pdf_state_e      state_reg;
   pdf_state_e      state_next;
   logic [7:0]      wake_cnt_reg;
   logic [7:0]      wake_cnt_next;
   logic            opt_reg;
   logic            opt_cap_reg;
   logic [2*PDF_WIDTH-1:0] out_pair;

   // build option caught once after reset release, a strap not a control
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         opt_reg     <= 1'b0;
         opt_cap_reg <= 1'b0;
      end else if (!opt_cap_reg) begin
         opt_reg     <= pd_option_i;
         opt_cap_reg <= 1'b1;
      end
   end

   // next state and recovery count
   always_comb begin
      state_next    = state_reg;
      wake_cnt_next = wake_cnt_reg;
      case (state_reg)
         PDF_RUN: begin
            if (opt_reg && sleep_request_pin_i) begin
               state_next = PDF_SLEEP;
            end
         end
         PDF_SLEEP: begin
            wake_cnt_next = WAKE_CNT_RST;
            if (!sleep_request_pin_i) begin
               state_next = PDF_WAKE;
            end
         end
         PDF_WAKE: begin
            if (sleep_request_pin_i) begin
               state_next = PDF_SLEEP;
            end else if (wake_cnt_reg == WAKE_CYC - 8'h01) begin
               state_next = PDF_RUN;
            end else begin
               wake_cnt_next = wake_cnt_reg + 8'h01;
            end
         end
         default: begin
            state_next = PDF_RUN;
         end
      endcase
   end

   // sequencing state
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_reg    <= PDF_RUN;
         wake_cnt_reg <= WAKE_CNT_RST;
      end else begin
         state_reg    <= state_next;
         wake_cnt_reg <= wake_cnt_next;
      end
   end

   // status flags follow the next state so they line up with state_reg
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         core_hold_o <= 1'b0;
         pd_active_o <= 1'b0;
         ready_o     <= 1'b1;
      end else begin
         core_hold_o <= (state_next != PDF_RUN);
         pd_active_o <= (state_next == PDF_SLEEP);
         ready_o     <= (state_next == PDF_RUN);
      end
   end

   // sleep pin kept off the core while the option is on, passed to it when the option is off
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         sleep_in_core_o <= 1'b0;
      end else begin
         sleep_in_core_o <= opt_reg ? 1'b0 : sleep_request_pin_i;
      end
   end

   // input blocking, hold latches; sampling stops one edge after
   // the sleep sample, well inside the allowed window
   // input sampling stops
   pdf_hold_latch #(
      .W       (PDF_WIDTH),
      .RST_VAL (HOLD_RST)
   ) u_in_hold (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .hold_i    (state_reg != PDF_RUN),
      .d_i       (pin_in_i),
      .q_o       (to_core_o)
   );

   // outputs held, tristate kept with its enable
   // macrocell outputs of the sleep pin still pass normally
   pdf_hold_latch #(
      .W       (2 * PDF_WIDTH),
      .RST_VAL ({HOLD_RST, HOLD_RST})
   ) u_out_hold (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .hold_i    (state_reg != PDF_RUN),
      .d_i       ({core_oe_i, core_out_i}),
      .q_o       (out_pair)
   );

   assign pin_out_o = out_pair[PDF_WIDTH-1:0];
   assign pin_oe_o  = out_pair[2*PDF_WIDTH-1:PDF_WIDTH];

   // sleep low while asleep starts recovery
   sequence s_wake_req;
      state_reg == PDF_SLEEP && !sleep_request_pin_i;
   endsequence

   sequence s_wake_quiet;
      !sleep_request_pin_i [*8];
   endsequence

   a_sleep_entry: assert property (@(posedge clk_i) disable iff (rst_i)
      (state_reg == PDF_RUN && opt_reg && sleep_request_pin_i)
      |=> (state_reg == PDF_SLEEP && pd_active_o && core_hold_o))
      else $error("sleep request not honoured");

   a_option_off: assert property (@(posedge clk_i) disable iff (rst_i)
      (opt_cap_reg && !opt_reg) |-> (state_reg == PDF_RUN && ready_o))
      else $error("power-down entered with option off");

   a_hold_outputs: assert property (@(posedge clk_i) disable iff (rst_i)
      (state_reg != PDF_RUN) |=> ($stable(pin_out_o) && $stable(pin_oe_o)))
      else $error("outputs changed during power-down");

   a_hiz_kept: assert property (@(posedge clk_i) disable iff (rst_i)
      (state_reg != PDF_RUN && $past(state_reg) != PDF_RUN)
      |-> ((pin_oe_o & ~$past(pin_oe_o)) == '0))
      else $error("tristated output enabled during power-down");

   a_block_inputs: assert property (@(posedge clk_i) disable iff (rst_i)
      (state_reg != PDF_RUN) |=> $stable(to_core_o))
      else $error("input reached core during power-down");

   a_pin_not_core: assert property (@(posedge clk_i) disable iff (rst_i)
      (opt_reg && $past(opt_reg)) |-> !sleep_in_core_o)
      else $error("sleep pin routed to core");

   a_stop_sample: assert property (@(posedge clk_i) disable iff (rst_i)
      (state_reg == PDF_RUN && opt_reg && sleep_request_pin_i)
      |-> ##[1:A_STOP_MAX] core_hold_o)
      else $error("sampling not stopped in time");

   a_wake_bound: assert property (@(posedge clk_i) disable iff (rst_i)
      s_wake_req ##1 s_wake_quiet |=> (state_reg == PDF_RUN && ready_o))
      else $error("recovery did not finish in time");

   a_release_late: assert property (@(posedge clk_i) disable iff (rst_i)
      (state_reg == PDF_RUN && $past(state_reg) != PDF_RUN)
      |-> ($past(state_reg) == PDF_WAKE && $past(core_hold_o, 2)))
      else $error("outputs released before recovery");

   a_rewake: assert property (@(posedge clk_i) disable iff (rst_i)
      (state_reg == PDF_WAKE && sleep_request_pin_i)
      |=> (state_reg == PDF_SLEEP && pd_active_o && !ready_o))
      else $error("sleep during recovery not honoured");

   a_wake_status: assert property (@(posedge clk_i) disable iff (rst_i)
      (state_reg == PDF_WAKE) |-> (core_hold_o && !pd_active_o && !ready_o))
      else $error("status flags wrong during recovery");

   a_option_pass: assert property (@(posedge clk_i) disable iff (rst_i)
      (opt_cap_reg && !opt_reg)
      |=> (sleep_in_core_o == $past(sleep_request_pin_i)))
      else $error("sleep pin not passed with option off");

   a_pass_inputs: assert property (@(posedge clk_i) disable iff (rst_i)
      (!$past(rst_i) && $past(state_reg) == PDF_RUN)
      |-> (to_core_o == $past(pin_in_i)))
      else $error("input pins not passed while running");

   a_pass_outputs: assert property (@(posedge clk_i) disable iff (rst_i)
      (!$past(rst_i) && $past(state_reg) == PDF_RUN)
      |-> (pin_out_o == $past(core_out_i) && pin_oe_o == $past(core_oe_i)))
      else $error("core outputs not passed while running");
endmodule
`default_nettype wire

// ===== logic/pdf_hold_latch.sv
// per-bit hold register: loads while open, keeps its value while held
// assumes hold_i comes from a flip-flop of the same clock
`timescale 1ns/1ps
`default_nettype none
module pdf_hold_latch #(
   parameter int unsigned    W       = 16,
   parameter logic [W-1:0]   RST_VAL = '0
) (
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic         hold_i,
   input  wire logic [W-1:0] d_i,
   output var  logic [W-1:0] q_o
);
   // one keeper per bit so a pin never floats to an undefined level
   // reset value is a parameter so the async branch stays constant
   genvar g;
   generate
      for (g = 0; g < W; g++) begin : g_bit
         always_ff @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
               q_o[g] <= RST_VAL[g];
            end else if (!hold_i) begin
               q_o[g] <= d_i[g];
            end
         end
      end
   endgenerate
endmodule
`default_nettype wire

// ===== logic/pdf_pkg.sv
// constants for the pin-controlled power-down freeze block
// assumes a single 250 MHz clock domain and synchronous pin inputs
package pdf_pkg;
   // pin group width of the frozen user path
   localparam int unsigned PDF_WIDTH = 16;
   // clock period in picoseconds
   localparam int unsigned CLK_PERIOD_PS = 4000;
   // least time the controller keeps pins valid before sleep, ns
   localparam int unsigned INPUT_VALID_BEFORE_SLEEP_NS = 15;
   // longest time before sampling stops after sleep rises, ns
   localparam int unsigned INPUT_RELEASE_AFTER_SLEEP_NS = 25;
   // longest time from sleep falling to valid outputs, us
   localparam int unsigned WAKE_TO_OUTPUT_VALID_US = 1;
   // least time rounds up
   localparam int unsigned INPUT_VALID_CYC =
      (INPUT_VALID_BEFORE_SLEEP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   // longest times round down
   localparam int unsigned STOP_MAX_CYC =
      (INPUT_RELEASE_AFTER_SLEEP_NS * 1000) / CLK_PERIOD_PS;
   localparam int unsigned WAKE_MAX_CYC =
      (WAKE_TO_OUTPUT_VALID_US * 1000000) / CLK_PERIOD_PS;
   // recovery length actually used, well inside the limit
   localparam logic [7:0] WAKE_CYC = 8'h08;
   localparam logic [7:0] WAKE_CNT_RST = 8'h00;
   // value of the held paths after reset
   localparam logic [PDF_WIDTH-1:0] HOLD_RST = 16'h0000;
   // power-down sequencing states
   typedef enum logic [1:0] {
      PDF_RUN,
      PDF_SLEEP,
      PDF_WAKE
   } pdf_state_e;
endpackage
